// ===== common/hpm_regs.vh
// register offsets, field positions and reset values of the hub port map bank
`ifndef HPM_REGS_VH
`define HPM_REGS_VH

// ----------------------------------------
// byte offsets
// ----------------------------------------
`define HPM_OFS_NUMCFG 8'h08
`define HPM_OFS_DIS_SELF 8'h2a
`define HPM_OFS_DIS_BUS 8'h2b
`define HPM_OFS_REMAP12 8'h36
`define HPM_OFS_REMAP3 8'h37
`define HPM_OFS_BOOST_UP 8'hf6
`define HPM_OFS_BOOST_DN 8'hf8
`define HPM_OFS_CTRL 8'hff
`define HPM_PROT_FIRST 8'h00
`define HPM_PROT_LAST 8'hfe

// ----------------------------------------
// field positions
// ----------------------------------------
`define HPM_NUMSEL_BIT 3
`define HPM_UPB_LSB 0
`define HPM_DN2_LSB 2
`define HPM_DN3_LSB 4
`define HPM_ATTACH_BIT 0
`define HPM_SRST_BIT 1
`define HPM_DIS_P1_BIT 1
`define HPM_DIS_P2_BIT 2
`define HPM_DIS_P3_BIT 3

// ----------------------------------------
// writable bits
// ----------------------------------------
`define HPM_WM_NUMCFG 8'h08
`define HPM_WM_BOOST_UP 8'h03
`define HPM_WM_BOOST_DN 8'h3c
`define HPM_WM_DIS 8'h0e
`define HPM_WM_REMAP12 8'hff
`define HPM_WM_REMAP3 8'h0f

// ----------------------------------------
// reset values
// ----------------------------------------
`define HPM_RST_NUMCFG 8'h00
`define HPM_RST_BOOST_UP 8'h00
`define HPM_RST_BOOST_DN 8'h00
`define HPM_RST_DIS 8'h00
`define HPM_RST_REMAP12 8'h21
`define HPM_RST_REMAP3 8'h03
`define HPM_RST_ATTACH 1'b1
`define HPM_RST_SRST 1'b0

`endif

// ===== tb/hpm_cfg_bench.sv
// self-checking bench of the hub port map register bank
`timescale 1ns/1ns
`default_nettype none
`include "hpm_regs.vh"
// ------------------------------
// bench top
// ------------------------------
module hpm_cfg_bench;
   logic sys_clk, resetn, self_powered, reg_wr, reg_rd, port_numbering_select;
   logic usb_attach, cfg_write_protect, soft_reset_pulse, wr_blocked;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q, d, ma, mb, r12, r3;
   logic [1:0] upstream_drive_boost, downstream2_drive_boost, downstream3_drive_boost;
   logic [3:0] port1_logical, port2_logical, port3_logical;
   int fail_count = 0, cmp_count = 0, cyc = 0, seed;
   hpm_cfg uut (.sys_clk, .resetn, .self_powered, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .port_numbering_select, .upstream_drive_boost, .downstream2_drive_boost,
      .downstream3_drive_boost, .usb_attach, .cfg_write_protect, .soft_reset_pulse,
      .wr_blocked, .port1_logical, .port2_logical, .port3_logical);
   hpm_loader ldr (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 5000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, s);
         fail_count++;
      end
   endtask
   function automatic logic [3:0] sn(input logic [3:1] dis, input int n);
      logic [3:0] c;
      c = 4'h1;
      for (int i = 1; i < n; i++) begin
         c = c + {3'h0, ~dis[i]};
      end
      return dis[n] ? 4'h0 : c;
   endfunction
   task automatic chk_ports(input logic m, input logic [3:1] dis, input logic [11:0] rm);
      chk("port1", 8'(m ? rm[3:0] : sn(dis, 1)), 8'(port1_logical));
      chk("port2", 8'(m ? rm[7:4] : sn(dis, 2)), 8'(port2_logical));
      chk("port3", 8'(m ? rm[11:8] : sn(dis, 3)), 8'(port3_logical));
   endtask
   initial begin
      seed = 61;
      resetn = 1'b0;
      self_powered = 1'b0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      @(negedge sys_clk);
      chk("attach", 8'h01, 8'(usb_attach));
      chk("numsel", 8'h00, 8'(port_numbering_select));
      chk("boost", 8'h00, 8'({downstream3_drive_boost, downstream2_drive_boost,
         upstream_drive_boost}));
      ldr.xfer(1'b0, 8'hff, 8'h00, q);
      chk("ctrl", 8'h01, q);
      chk_ports(1'b0, 3'h0, 12'h000);
      ldr.xfer(1'b1, 8'hf6, 8'h03, q);
      chk("blocked", 8'h01, 8'(wr_blocked));
      chk("up held", 8'h00, 8'(upstream_drive_boost));
      ldr.xfer(1'b1, 8'hff, 8'h00, q);
      ldr.xfer(1'b1, 8'hff, 8'h01, q);
      chk("attach", 8'h00, 8'(usb_attach));
      chk("protect", 8'h00, 8'(cfg_write_protect));
      ldr.xfer(1'b0, 8'h55, 8'h00, q);
      chk("unmapped", 8'h00, q);
      for (int k = 0; k < 24; k++) begin
         d = (k == 0) ? 8'hff : (k == 1) ? 8'h40 : (k == 2) ? 8'h00 : 8'($random(seed));
         ma = (k == 1) ? 8'h0e : 8'($random(seed));
         mb = (k == 2) ? 8'h02 : 8'($random(seed));
         r12 = 8'($random(seed));
         r3 = 8'($random(seed));
         @(posedge sys_clk);
         self_powered <= d[6];
         ldr.xfer(1'b1, 8'h08, d, q);
         ldr.xfer(1'b1, 8'hf6, d, q);
         ldr.xfer(1'b1, 8'hf8, d, q);
         ldr.xfer(1'b1, 8'h2a, ma, q);
         ldr.xfer(1'b1, 8'h2b, mb, q);
         ldr.xfer(1'b1, 8'h36, r12, q);
         ldr.xfer(1'b1, 8'h37, r3, q);
         chk("dn3", 8'(d[5:4]), 8'(downstream3_drive_boost));
         chk("dn2", 8'(d[3:2]), 8'(downstream2_drive_boost));
         chk("up", 8'(d[1:0]), 8'(upstream_drive_boost));
         chk("numsel", 8'(d[3]), 8'(port_numbering_select));
         ldr.xfer(1'b0, 8'hf8, 8'h00, q);
         chk("dn rd", d & 8'h3c, q);
         ldr.xfer(1'b0, 8'h08, 8'h00, q);
         chk("cfg rd", d & 8'h08, q);
         chk_ports(d[3], d[6] ? ma[3:1] : mb[3:1], {r3[3:0], r12});
      end
      ldr.xfer(1'b1, 8'hff, 8'h02, q);
      chk("srst", 8'h01, 8'(soft_reset_pulse));
      @(negedge sys_clk);
      chk("srst", 8'h00, 8'(soft_reset_pulse));
      chk("up", 8'h00, 8'(upstream_drive_boost));
      ldr.xfer(1'b0, 8'hff, 8'h00, q);
      chk("ctrl", 8'h00, q);
      ldr.xfer(1'b0, 8'h36, 8'h00, q);
      chk("remap", `HPM_RST_REMAP12, q);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ===== tb/hpm_cfg_monitor.sv
// checker for the hub port map register bank
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// port checks
// ------------------------------
module hpm_cfg_monitor (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic port_numbering_select,
   input wire logic [1:0] upstream_drive_boost,
   input wire logic [1:0] downstream2_drive_boost,
   input wire logic [1:0] downstream3_drive_boost,
   input wire logic usb_attach,
   input wire logic cfg_write_protect,
   input wire logic soft_reset_pulse,
   input wire logic wr_blocked
);
   logic [7:0] wd_q;
   wire logic ok_wr = reg_wr && !usb_attach && !soft_reset_pulse;
   always_ff @(posedge sys_clk) begin
      wd_q <= reg_wdata;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_srst_req;
      reg_wr && reg_addr == 8'hff && reg_wdata[1];
   endsequence
   sequence s_one_pulse;
      soft_reset_pulse ##1 !soft_reset_pulse;
   endsequence
   AST_WP_EQ: assert property (cfg_write_protect == usb_attach)
      else $error("protect differs");
   AST_BLOCK: assert property (reg_wr && usb_attach && reg_addr != 8'hff
      && !soft_reset_pulse |=> wr_blocked && $stable(upstream_drive_boost))
      else $error("write not blocked");
   AST_NOBLOCK: assert property (reg_wr && !usb_attach |=> !wr_blocked)
      else $error("write refused");
   AST_SRST: assert property (s_srst_req ##1 !(reg_wr && reg_addr == 8'hff && reg_wdata[1])
      |-> s_one_pulse) else $error("soft reset pulse");
   AST_SRST_CLR: assert property (soft_reset_pulse |=> upstream_drive_boost == 2'b00
      && downstream2_drive_boost == 2'b00 && downstream3_drive_boost == 2'b00
      && !port_numbering_select) else $error("soft reset defaults");
   AST_ONCE: assert property (!usb_attach |=> !usb_attach)
      else $error("attach set again");
   AST_UPB: assert property (ok_wr && reg_addr == 8'hf6
      |=> upstream_drive_boost == wd_q[1:0]) else $error("upstream boost");
   AST_DNB: assert property (ok_wr && reg_addr == 8'hf8
      |=> {downstream3_drive_boost, downstream2_drive_boost} == wd_q[5:2])
      else $error("downstream boost");
   AST_NUMSEL: assert property (ok_wr && reg_addr == 8'h08
      |=> port_numbering_select == wd_q[3]) else $error("numbering select");
   AST_RSVD: assert property (reg_rd && reg_addr == 8'hf8
      |=> (reg_rdata & 8'hc3) == 8'h00) else $error("reserved bits");
endmodule
bind hpm_cfg hpm_cfg_monitor u_mon (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .port_numbering_select, .upstream_drive_boost,
   .downstream2_drive_boost, .downstream3_drive_boost, .usb_attach, .cfg_write_protect,
   .soft_reset_pulse, .wr_blocked);
`default_nettype wire

// ===== tb/hpm_loader.sv
// configuration loader model on the register port
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// loader
// ------------------------------
module hpm_loader (
   input wire logic sys_clk,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one strobe, then released lines show inverted values
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      @(negedge sys_clk);
      q = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ===== verilog/hpm_cfg.v
// hub port numbering, drive boost and attach control register bank
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "hpm_regs.vh"

module hpm_cfg (
   input wire sys_clk,
   input wire resetn,
   input wire self_powered,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   output wire port_numbering_select,
   output wire [1:0] upstream_drive_boost,
   output wire [1:0] downstream2_drive_boost,
   output wire [1:0] downstream3_drive_boost,
   output wire usb_attach,
   output wire cfg_write_protect,
   output wire soft_reset_pulse,
   output wire wr_blocked,
   output wire [3:0] port1_logical,
   output wire [3:0] port2_logical,
   output wire [3:0] port3_logical
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg sp_meta_q;
   reg sp_sync_q;
   reg attach_q;
   reg attach_lock_q;
   reg srst_q;
   reg blocked_q;
   reg [7:0] rdata_q;
   reg [7:0] rdata_d;
   reg [3:0] p1_q;
   reg [3:0] p2_q;
   reg [3:0] p3_q;
   reg [3:0] p1_d;
   reg [3:0] p2_d;
   reg [3:0] p3_d;

   wire sel_numcfg;
   wire sel_dis_self;
   wire sel_dis_bus;
   wire sel_remap12;
   wire sel_remap3;
   wire sel_boost_up;
   wire sel_boost_dn;
   wire sel_ctrl;
   wire prot_hit;
   wire cfg_wr_ok;

   wire [7:0] numcfg;
   wire [7:0] dis_self;
   wire [7:0] dis_bus;
   wire [7:0] remap12;
   wire [7:0] remap3;
   wire [7:0] boost_up;
   wire [7:0] boost_dn;
   wire [7:0] ctrl_rd;
   wire [7:0] dis_mask;

   wire en1;
   wire en2;
   wire en3;

   // ----------------------------------------
   // self-powered pin synchroniser
   // ----------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sp_meta_q <= 1'b0;
         sp_sync_q <= 1'b0;
      end else begin
         sp_meta_q <= self_powered;
         sp_sync_q <= sp_meta_q;
      end
   end

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   assign sel_numcfg = (reg_addr == `HPM_OFS_NUMCFG);
   assign sel_dis_self = (reg_addr == `HPM_OFS_DIS_SELF);
   assign sel_dis_bus = (reg_addr == `HPM_OFS_DIS_BUS);
   assign sel_remap12 = (reg_addr == `HPM_OFS_REMAP12);
   assign sel_remap3 = (reg_addr == `HPM_OFS_REMAP3);
   assign sel_boost_up = (reg_addr == `HPM_OFS_BOOST_UP);
   assign sel_boost_dn = (reg_addr == `HPM_OFS_BOOST_DN);
   assign sel_ctrl = (reg_addr == `HPM_OFS_CTRL);

   assign prot_hit = (reg_addr <= `HPM_PROT_LAST);

   assign cfg_wr_ok = reg_wr && !(attach_q && prot_hit);

   // ----------------------------------------
   // configuration bytes
   // ----------------------------------------
   // numbering select byte
   hpm_reg8 #(
      .RST_VAL(`HPM_RST_NUMCFG),
      .WR_MASK(`HPM_WM_NUMCFG)
   ) u_numcfg (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .soft_clr(srst_q),
      .wr_en(cfg_wr_ok && sel_numcfg),
      .wr_data(reg_wdata),
      .q(numcfg)
   );

   hpm_reg8 #(
      .RST_VAL(`HPM_RST_DIS),
      .WR_MASK(`HPM_WM_DIS)
   ) u_dis_self (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .soft_clr(srst_q),
      .wr_en(cfg_wr_ok && sel_dis_self),
      .wr_data(reg_wdata),
      .q(dis_self)
   );

   hpm_reg8 #(
      .RST_VAL(`HPM_RST_DIS),
      .WR_MASK(`HPM_WM_DIS)
   ) u_dis_bus (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .soft_clr(srst_q),
      .wr_en(cfg_wr_ok && sel_dis_bus),
      .wr_data(reg_wdata),
      .q(dis_bus)
   );

   hpm_reg8 #(
      .RST_VAL(`HPM_RST_REMAP12),
      .WR_MASK(`HPM_WM_REMAP12)
   ) u_remap12 (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .soft_clr(srst_q),
      .wr_en(cfg_wr_ok && sel_remap12),
      .wr_data(reg_wdata),
      .q(remap12)
   );

   hpm_reg8 #(
      .RST_VAL(`HPM_RST_REMAP3),
      .WR_MASK(`HPM_WM_REMAP3)
   ) u_remap3 (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .soft_clr(srst_q),
      .wr_en(cfg_wr_ok && sel_remap3),
      .wr_data(reg_wdata),
      .q(remap3)
   );

   hpm_reg8 #(
      .RST_VAL(`HPM_RST_BOOST_UP),
      .WR_MASK(`HPM_WM_BOOST_UP)
   ) u_boost_up (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .soft_clr(srst_q),
      .wr_en(cfg_wr_ok && sel_boost_up),
      .wr_data(reg_wdata),
      .q(boost_up)
   );

   hpm_reg8 #(
      .RST_VAL(`HPM_RST_BOOST_DN),
      .WR_MASK(`HPM_WM_BOOST_DN)
   ) u_boost_dn (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .soft_clr(srst_q),
      .wr_en(cfg_wr_ok && sel_boost_dn),
      .wr_data(reg_wdata),
      .q(boost_dn)
   );

   // ----------------------------------------
   // control byte
   // ----------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         attach_q <= `HPM_RST_ATTACH;
         attach_lock_q <= 1'b0;
         srst_q <= `HPM_RST_SRST;
      end else begin
         srst_q <= reg_wr && sel_ctrl && reg_wdata[`HPM_SRST_BIT];
         if (reg_wr && sel_ctrl && !attach_lock_q) begin
            attach_q <= reg_wdata[`HPM_ATTACH_BIT];
            attach_lock_q <= 1'b1;
         end
      end
   end

   assign ctrl_rd = {6'h00, srst_q, attach_q};

   // ----------------------------------------
   // blocked write indication
   // ----------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         blocked_q <= 1'b0;
      end else begin
         blocked_q <= reg_wr && attach_q && prot_hit;
      end
   end

   // ----------------------------------------
   // port numbering
   // ----------------------------------------
   // mask chosen by power source
   assign dis_mask = sp_sync_q ? dis_self : dis_bus;

   assign en1 = !dis_mask[`HPM_DIS_P1_BIT];
   assign en2 = !dis_mask[`HPM_DIS_P2_BIT];
   assign en3 = !dis_mask[`HPM_DIS_P3_BIT];

   always @* begin
      p1_d = 4'h0;
      p2_d = 4'h0;
      p3_d = 4'h0;
      if (numcfg[`HPM_NUMSEL_BIT]) begin
         p1_d = remap12[3:0];
         p2_d = remap12[7:4];
         p3_d = remap3[3:0];
      end else begin
         if (en1) begin
            p1_d = 4'h1;
         end
         if (en2) begin
            p2_d = {3'h0, en1} + 4'h1;
         end
         if (en3) begin
            p3_d = {3'h0, en1} + {3'h0, en2} + 4'h1;
         end
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         p1_q <= 4'h0;
         p2_q <= 4'h0;
         p3_q <= 4'h0;
      end else begin
         p1_q <= p1_d;
         p2_q <= p2_d;
         p3_q <= p3_d;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always @* begin
      rdata_d = 8'h00;
      case (reg_addr)
         `HPM_OFS_NUMCFG: begin
            rdata_d = numcfg;
         end
         `HPM_OFS_DIS_SELF: begin
            rdata_d = dis_self;
         end
         `HPM_OFS_DIS_BUS: begin
            rdata_d = dis_bus;
         end
         `HPM_OFS_REMAP12: begin
            rdata_d = remap12;
         end
         `HPM_OFS_REMAP3: begin
            rdata_d = remap3;
         end
         `HPM_OFS_BOOST_UP: begin
            rdata_d = boost_up;
         end
         `HPM_OFS_BOOST_DN: begin
            rdata_d = boost_dn;
         end
         `HPM_OFS_CTRL: begin
            rdata_d = ctrl_rd;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata = rdata_q;

   assign port_numbering_select = numcfg[`HPM_NUMSEL_BIT];

   assign upstream_drive_boost = boost_up[`HPM_UPB_LSB+1:`HPM_UPB_LSB];

   assign downstream2_drive_boost = boost_dn[`HPM_DN2_LSB+1:`HPM_DN2_LSB];

   assign downstream3_drive_boost = boost_dn[`HPM_DN3_LSB+1:`HPM_DN3_LSB];

   assign usb_attach = attach_q;
   assign cfg_write_protect = attach_q;

   assign soft_reset_pulse = srst_q;
   assign wr_blocked = blocked_q;

   assign port1_logical = p1_q;
   assign port2_logical = p2_q;
   assign port3_logical = p3_q;

endmodule

`default_nettype wire

// ===== verilog/hpm_reg8.v
// one configuration byte with write mask, soft clear and async reset
`timescale 1ns/1ns
`default_nettype none

module hpm_reg8 #(
   parameter [7:0] RST_VAL = 8'h00,
   parameter [7:0] WR_MASK = 8'hff
) (
   input wire sys_clk,
   input wire resetn,
   input wire soft_clr,
   input wire wr_en,
   input wire [7:0] wr_data,
   output wire [7:0] q
);

   reg [7:0] byte_q;
   reg [7:0] byte_d;

   // ----------------------------------------
   // next value
   // ----------------------------------------
   always @* begin
      byte_d = byte_q;
      if (soft_clr) begin
         byte_d = RST_VAL;
      end else if (wr_en) begin
         byte_d = (wr_data & WR_MASK) | (byte_q & ~WR_MASK);
      end
   end

   // ----------------------------------------
   // storage
   // ----------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         byte_q <= RST_VAL;
      end else begin
         byte_q <= byte_d;
      end
   end

   assign q = byte_q;

endmodule

`default_nettype wire
